// ### rtl/adcsc_pkg.sv
package adcsc_pkg;
    // Register word indexes; the APB byte address is four times the index
    localparam logic [7:0] IDX_STATUS   = 8'h06;
    localparam logic [7:0] IDX_CMP_EN   = 8'h08;
    localparam logic [7:0] IDX_CMP_SENS = 8'h0E;
    localparam logic [7:0] IDX_START    = 8'h05;
    localparam logic [7:0] IDX_SETUP    = 8'h00;
    localparam logic [7:0] IDX_SETUP_N  = 8'h05;
    localparam logic [7:0] IDX_CTRL     = 8'h10;
    localparam logic [7:0] IDX_DONE     = 8'h0A;
    localparam logic [7:0] IDX_RESULT   = 8'h20;
    localparam logic [7:0] IDX_IRQ_ST   = 8'h11;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h12;
    localparam int          ADDR_W      = 12;
    // Status field positions
    localparam int BIT_SEQ_DONE  = 7;
    localparam int BIT_UNUSED    = 6;
    localparam int BIT_TRIG_OVR  = 5;
    localparam int BIT_RES_OVR   = 4;
    localparam int PTR_MSB       = 3;
    // Control register field positions
    localparam int BIT_SCAN      = 0;
    localparam int BIT_FIFO      = 1;
    localparam int BIT_FAST_CLR  = 2;
    localparam int BIT_TRIG_LVL  = 3;
    localparam int BIT_TRIG_EN   = 4;
    // Interrupt status bits
    localparam int IRQ_SEQ_DONE  = 0;
    localparam int IRQ_TRIG_OVR  = 1;
    localparam int IRQ_RES_OVR   = 2;
    localparam int IRQ_CMP_HIT   = 3;
    localparam int IRQ_W         = 4;
    // Reset values
    localparam logic [15:0] RST_CMP_EN   = 16'h0000;
    localparam logic [15:0] RST_CMP_SENS = 16'h0000;
    localparam logic [7:0]  RST_CTRL     = 8'h00;
    localparam logic [3:0]  RST_IRQ_MASK = 4'h0;
    // Last conversion position of a sequence (16 conversions)
    localparam logic [3:0]  SEQ_LAST     = 4'hF;
    // Conversion time per position
    localparam int          CONV_NS      = 100;
    localparam int          CLK_NS       = 5;
    localparam int          CONV_CYC     = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  CONV_CYC_W   = 8'(CONV_CYC);
    typedef enum logic [1:0] {ADCSC_IDLE, ADCSC_CONV, ADCSC_STORE} adcsc_state_t;
endpackage

// ### rtl/adcsc_flag.sv
`timescale 1ns/1ps
// Sticky flag: set wins over soft clear, hard clear wins over all
module adcsc_flag (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic soft_clr,
    input  wire logic hard_clr,
    output logic      flag_ff
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
        end else if (hard_clr) begin
            flag_ff <= 1'b0;
        end else if (set) begin
            flag_ff <= 1'b1;
        end else if (soft_clr) begin
            flag_ff <= 1'b0;
        end
    end
endmodule

// ### rtl/adcsc_top.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
// What this block does
// - Set sequence done at each sequence end
// - Clear done by W1C, start, fast read
// - Edge trigger during sequence sets trigger overrun
// - Trigger overrun cleared by W1C, setup, start
// - Result write with done set flags overrun
// - Result overrun cleared by W1C, setup, start
// - Compare/setup writes abort running sequence
// - Read-only 4-bit conversion pointer
// - Pointer zeroed at sequence ends unless FIFO
// - Pointer wraps from maximum to zero
// - Abort or start always clears pointer
// - Sixteen compare enables with sense select
// - Done flag reports compare success
// - Compare mode discards result, flags hit
// - Sense zero lower-or-same, one higher
// - Scan bit selects single or continuous while trigger enable is clear
module adcsc_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trig,
    input  wire logic [11:0] conv_sample,
    output logic             busy,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic                   acc;
    logic                   wr;
    logic                   rd;
    logic [9:0]             widx;
    logic                   hit_status;
    logic                   wr_start;
    logic                   wr_setup;
    logic                   wr_cmp;
    logic                   wr_status;
    logic                   wr_result;
    logic                   rd_result;
    logic [3:0]             ridx;
    logic [15:0]            cmp_en_ff;
    logic [15:0]            cmp_sens_ff;
    logic [7:0]             ctrl_ff;
    logic [15:0]            done_ff;
    logic [11:0]            result_ff [16];
    logic [3:0]             ptr_ff;
    logic [7:0]             cnt_ff;
    logic                   trig_d_ff;
    logic                   trig_edge;
    logic                   abort;
    logic                   seq_end;
    logic                   conv_end;
    logic                   cmp_true;
    logic [3:0]             irq_st_ff;
    logic [3:0]             irq_mask_ff;
    logic [3:0]             irq_set;
    logic                   seq_done_flag;
    logic                   trig_overrun_flag;
    logic                   result_overrun_flag;
    logic [31:0]            nxt_prdata;
    adcsc_pkg::adcsc_state_t state_ff;

    assign acc  = psel && penable && pready;
    assign wr   = acc && pwrite;
    assign rd   = acc && !pwrite;
    assign widx = paddr[11:2];
    assign ridx = widx[3:0];
    assign hit_status = widx == 10'(adcsc_pkg::IDX_STATUS);
    assign wr_start  = wr && widx == 10'(adcsc_pkg::IDX_START);
    assign wr_setup  = wr && widx >= 10'(adcsc_pkg::IDX_SETUP)
                          && widx < 10'(adcsc_pkg::IDX_SETUP_N);
    assign wr_cmp    = wr && (widx == 10'(adcsc_pkg::IDX_CMP_EN)
                          || widx == 10'(adcsc_pkg::IDX_CMP_SENS));
    assign wr_status = wr && hit_status;
    assign wr_result = wr && widx[9:4] == 6'(adcsc_pkg::IDX_RESULT[7:4]);
    assign rd_result = rd && widx[9:4] == 6'(adcsc_pkg::IDX_RESULT[7:4]);
    ////////////////////////////////////////////////////////////////////////////
    // abort on setup or compare writes
    assign abort = wr_setup || wr_cmp;
    assign trig_edge = ext_trig && !trig_d_ff;
    assign conv_end = state_ff == adcsc_pkg::ADCSC_CONV
                      && cnt_ff == adcsc_pkg::CONV_CYC_W;
    assign seq_end  = conv_end && ptr_ff == adcsc_pkg::SEQ_LAST;
    assign cmp_true = cmp_sens_ff[ptr_ff] ? (conv_sample > result_ff[ptr_ff])
                                          : (conv_sample <= result_ff[ptr_ff]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_d_ff <= 1'b0;
        end else begin
            trig_d_ff <= ext_trig;
        end
    end

    // Sequencer; scan restarts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= adcsc_pkg::ADCSC_IDLE;
        end else if (abort) begin
            state_ff <= adcsc_pkg::ADCSC_IDLE;
        end else begin
            case (state_ff)
                adcsc_pkg::ADCSC_IDLE: begin
                    if (wr_start || (ctrl_ff[adcsc_pkg::BIT_TRIG_EN] && trig_edge)) begin
                        state_ff <= adcsc_pkg::ADCSC_CONV;
                    end
                end
                adcsc_pkg::ADCSC_CONV: begin
                    if (wr_start) begin
                        state_ff <= adcsc_pkg::ADCSC_CONV;
                    end else if (seq_end && !(ctrl_ff[adcsc_pkg::BIT_SCAN]
                                 && !ctrl_ff[adcsc_pkg::BIT_TRIG_EN])) begin
                        state_ff <= adcsc_pkg::ADCSC_IDLE;
                    end
                end
                default: state_ff <= adcsc_pkg::ADCSC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
        end else if (abort || wr_start || state_ff != adcsc_pkg::ADCSC_CONV || conv_end) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_ff <= 4'h0;
        end else if (abort || wr_start) begin
            ptr_ff <= 4'h0;
        end else if (seq_end && !ctrl_ff[adcsc_pkg::BIT_FIFO]) begin
            ptr_ff <= 4'h0;
        end else if (conv_end) begin
            ptr_ff <= ptr_ff + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_en_ff   <= adcsc_pkg::RST_CMP_EN;
            cmp_sens_ff <= adcsc_pkg::RST_CMP_SENS;
            ctrl_ff     <= adcsc_pkg::RST_CTRL;
            irq_mask_ff <= adcsc_pkg::RST_IRQ_MASK;
        end else if (wr) begin
            if (widx == 10'(adcsc_pkg::IDX_CMP_EN))   cmp_en_ff   <= pwdata[15:0];
            if (widx == 10'(adcsc_pkg::IDX_CMP_SENS)) cmp_sens_ff <= pwdata[15:0];
            if (widx == 10'(adcsc_pkg::IDX_CTRL))     ctrl_ff     <= pwdata[7:0];
            if (widx == 10'(adcsc_pkg::IDX_IRQ_MASK)) irq_mask_ff <= pwdata[3:0];
        end
    end

    // Result / compare value store
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                result_ff[i] <= 12'h000;
            end
        end else if (wr_result) begin
            result_ff[ridx] <= pwdata[11:0];
        end else if (conv_end && !cmp_en_ff[ptr_ff]) begin
            result_ff[ptr_ff] <= conv_sample;
        end
    end

    // Conversion done flags; compare success reported
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_ff <= 16'h0000;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (wr_start) begin
                    done_ff[i] <= 1'b0;
                end else if (conv_end && ptr_ff == 4'(i)
                             && (!cmp_en_ff[i] || cmp_true)) begin
                    done_ff[i] <= 1'b1;
                end else if (ctrl_ff[adcsc_pkg::BIT_FAST_CLR]
                             && ((rd_result && !cmp_en_ff[i])
                             || (wr_result && cmp_en_ff[i])) && ridx == 4'(i)) begin
                    done_ff[i] <= 1'b0;
                end else if (!ctrl_ff[adcsc_pkg::BIT_FAST_CLR] && wr
                             && widx == 10'(adcsc_pkg::IDX_DONE) && pwdata[i]) begin
                    done_ff[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence done set; clears
    adcsc_flag u_seq_done (
        .clk      (clk),
        .rst_n    (rst_n),
        .set      (seq_end && !abort),
        .soft_clr ((wr_status && pwdata[adcsc_pkg::BIT_SEQ_DONE])
                   || (rd_result && ctrl_ff[adcsc_pkg::BIT_FAST_CLR])),
        .hard_clr (wr_start),
        .flag_ff  (seq_done_flag)
    );

    adcsc_flag u_trig_ovr (
        .clk      (clk),
        .rst_n    (rst_n),
        .set      (state_ff == adcsc_pkg::ADCSC_CONV && trig_edge
                   && ctrl_ff[adcsc_pkg::BIT_TRIG_EN] && !ctrl_ff[adcsc_pkg::BIT_TRIG_LVL]),
        .soft_clr (wr_status && pwdata[adcsc_pkg::BIT_TRIG_OVR]),
        .hard_clr (abort || wr_start),
        .flag_ff  (trig_overrun_flag)
    );

    adcsc_flag u_res_ovr (
        .clk      (clk),
        .rst_n    (rst_n),
        .set      (conv_end && !cmp_en_ff[ptr_ff] && done_ff[ptr_ff]),
        .soft_clr (wr_status && pwdata[adcsc_pkg::BIT_RES_OVR]),
        .hard_clr (abort || wr_start),
        .flag_ff  (result_overrun_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign irq_set[adcsc_pkg::IRQ_SEQ_DONE] = seq_end && !abort;
    assign irq_set[adcsc_pkg::IRQ_TRIG_OVR] = state_ff == adcsc_pkg::ADCSC_CONV && trig_edge
                   && ctrl_ff[adcsc_pkg::BIT_TRIG_EN] && !ctrl_ff[adcsc_pkg::BIT_TRIG_LVL];
    assign irq_set[adcsc_pkg::IRQ_RES_OVR]  = conv_end && !cmp_en_ff[ptr_ff] && done_ff[ptr_ff];
    assign irq_set[adcsc_pkg::IRQ_CMP_HIT]  = conv_end && cmp_en_ff[ptr_ff] && cmp_true;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_st_ff <= 4'h0;
        end else if (wr && widx == 10'(adcsc_pkg::IDX_IRQ_ST)) begin
            irq_st_ff <= (irq_st_ff & ~pwdata[3:0]) | irq_set;
        end else begin
            irq_st_ff <= irq_st_ff | irq_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq  <= 1'b0;
            busy <= 1'b0;
        end else begin
            irq  <= |(irq_st_ff & irq_mask_ff);
            busy <= state_ff != adcsc_pkg::ADCSC_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (hit_status) begin
            nxt_prdata[7:0] = {seq_done_flag, 1'b0, trig_overrun_flag,
                               result_overrun_flag, ptr_ff};
        end else if (widx == 10'(adcsc_pkg::IDX_CMP_EN)) begin
            nxt_prdata[15:0] = cmp_en_ff;
        end else if (widx == 10'(adcsc_pkg::IDX_CMP_SENS)) begin
            nxt_prdata[15:0] = cmp_sens_ff;
        end else if (widx == 10'(adcsc_pkg::IDX_CTRL)) begin
            nxt_prdata[7:0] = ctrl_ff;
        end else if (widx == 10'(adcsc_pkg::IDX_DONE)) begin
            nxt_prdata[15:0] = done_ff;
        end else if (widx == 10'(adcsc_pkg::IDX_IRQ_ST)) begin
            nxt_prdata[3:0] = irq_st_ff;
        end else if (widx == 10'(adcsc_pkg::IDX_IRQ_MASK)) begin
            nxt_prdata[3:0] = irq_mask_ff;
        end else if (widx[9:4] == 6'(adcsc_pkg::IDX_RESULT[7:4])) begin
            nxt_prdata[11:0] = result_ff[ridx];
        end
    end

    // No wait state: answer in first access cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= nxt_prdata;
            pslverr <= 1'b0;
        end
    end
endmodule

// ### verif/adcsc_chk.sv
`timescale 1ns/1ps
module adcsc_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_trig,
    input wire logic [11:0] conv_sample,
    input wire logic        busy,
    input wire logic        irq
);
    localparam logic [11:0] A_ST = {2'b00, adcsc_pkg::IDX_STATUS, 2'b00};
    localparam logic [11:0] A_EN = {2'b00, adcsc_pkg::IDX_CMP_EN, 2'b00};
    localparam logic [11:0] A_SN = {2'b00, adcsc_pkg::IDX_CMP_SENS, 2'b00};
    localparam logic [11:0] A_GO = {2'b00, adcsc_pkg::IDX_START, 2'b00};
    localparam logic [11:0] A_SU = {2'b00, adcsc_pkg::IDX_SETUP_N, 2'b00};
    logic wr_acc;
    logic rd_acc;
    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = psel && penable && pready && !pwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    setup_ready_a:
        assert property (psel && !penable |=> pready) else $error("no pready after setup");
    ready_pulse_a:
        assert property (pready |-> psel && penable && !pslverr ##1 !pready)
        else $error("pready not a single clean access");
    bit6_zero_a:
        assert property (rd_acc && paddr == A_ST |-> prdata[31:8] == 24'h0 && !prdata[6])
        else $error("status unused bits not zero");
    start_run_a:
        assert property (wr_acc && paddr == A_GO |-> ##[1:3] busy) else $error("start ignored");
    cmp_abort_a:
        assert property (wr_acc && (paddr == A_EN || paddr == A_SN) |-> ##[1:3] !busy)
        else $error("compare write did not abort");
    setup_abort_a:
        assert property (wr_acc && paddr < A_SU |-> ##[1:3] !busy)
        else $error("setup write did not abort");
    rst_quiet_a:
        assert property ($rose(rst_n) |-> !busy && !irq) else $error("outputs active after reset");
    run_len_a:
        assert property ($rose(busy) |-> busy[*8]) else $error("sequence ended too early");
endmodule

bind adcsc_top adcsc_chk adcsc_chk_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig(ext_trig), .conv_sample(conv_sample), .busy(busy), .irq(irq)
);

// ### verif/adcsc_top_tb.sv
`timescale 1ns/1ps
module adcsc_top_tb;
    localparam logic [7:0] ST = adcsc_pkg::IDX_STATUS;
    localparam logic [7:0] EN = adcsc_pkg::IDX_CMP_EN;
    localparam logic [7:0] SN = adcsc_pkg::IDX_CMP_SENS;
    localparam logic [7:0] GO = adcsc_pkg::IDX_START;
    localparam logic [7:0] CT = adcsc_pkg::IDX_CTRL;
    localparam logic [7:0] DN = adcsc_pkg::IDX_DONE;
    localparam logic [7:0] RS = adcsc_pkg::IDX_RESULT;
    localparam logic [7:0] IS = adcsc_pkg::IDX_IRQ_ST;
    localparam logic [7:0] MK = adcsc_pkg::IDX_IRQ_MASK;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_trig;
    logic [11:0] conv_sample;
    logic        busy;
    logic        irq;
    logic [31:0] rdv;
    int          err_total;
    int          cmp_count;

    adcsc_top adcsc_top_i (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trig(ext_trig), .conv_sample(conv_sample), .busy(busy), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            end_sim();
        end
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] m,
                       input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        chk(nm, rdv & m, e);
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (busy !== lvl) begin
            err_total++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_regs;
        rdc("cmp_enable reset", EN, 32'hFFFF, {16'h0, adcsc_pkg::RST_CMP_EN});
        rdc("status reset", ST, 32'hFF, 32'h0);
        bus(1'b1, EN, 32'h0000A5C3);
        rdc("cmp_enable rw", EN, 32'hFFFF, 32'hA5C3);
        bus(1'b1, EN, 32'h0);
        rdc("unmapped", 8'hFF, 32'hFFFFFFFF, 32'h0);
    endtask

    task automatic s_single;
        bus(1'b1, MK, 32'h1);
        bus(1'b1, GO, 32'h0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rdc("seq done", ST, 32'hFF, 32'h80);
        repeat (2) @(posedge clk);
        chk("irq set", 32'(irq), 32'h1);
        bus(1'b1, ST, 32'h4F);
        rdc("read only bits", ST, 32'hFF, 32'h80);
        bus(1'b1, ST, 32'h80);
        rdc("done w1c", ST, 32'h80, 32'h0);
        bus(1'b1, IS, 32'hF);
        repeat (2) @(posedge clk);
        chk("irq clear", 32'(irq), 32'h0);
        bus(1'b1, MK, 32'h0);
        bus(1'b1, GO, 32'h0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        bus(1'b1, GO, 32'h0);
        rdc("start clear", ST, 32'h80, 32'h0);
        wait_busy(1'b0);
        bus(1'b1, CT, 32'h4);
        rdc("result read", RS, 32'hFFF, 32'h5A5);
        rdc("fast clear", ST, 32'h80, 32'h0);
    endtask

    task automatic s_abort;
        logic [7:0] tgt [3] = '{EN, SN, 8'h02};
        bus(1'b1, CT, 32'h2);
        foreach (tgt[i]) begin
            bus(1'b1, GO, 32'h0);
            repeat (50) @(posedge clk);
            bus(1'b1, tgt[i], 32'h0);
            repeat (3) @(posedge clk);
            chk("abort busy", 32'(busy), 32'h0);
            rdc("abort pointer", ST, 32'h0F, 32'h0);
        end
        bus(1'b1, GO, 32'h0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rdc("fifo wrap", ST, 32'h0F, 32'h0);
        bus(1'b1, CT, 32'h0);
        bus(1'b1, ST, 32'h80);
    endtask

    task automatic s_scan;
        int n;
        bus(1'b1, CT, 32'h1);
        bus(1'b1, GO, 32'h0);
        n = 0;
        do begin
            bus(1'b0, ST, 32'h0);
            n++;
        end while (rdv[4] !== 1'b1 && n < 400);
        chk("result overrun", rdv & 32'h90, 32'h90);
        chk("scan busy", 32'(busy), 32'h1);
        bus(1'b1, SN, 32'h0);
        rdc("overrun clear", ST, 32'hB0, 32'h80);
        bus(1'b1, CT, 32'h0);
        bus(1'b1, ST, 32'h80);
    endtask

    task automatic s_cmp;
        bus(1'b1, EN, 32'h1);
        bus(1'b1, RS, 32'hFFFF);
        bus(1'b1, GO, 32'h0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rdc("cmp lower", DN, 32'h1, 32'h1);
        rdc("cmp value kept", RS, 32'hFFF, 32'hFFF);
        bus(1'b1, SN, 32'h1);
        bus(1'b1, GO, 32'h0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rdc("cmp higher", DN, 32'h1, 32'h0);
        bus(1'b1, EN, 32'h0);
        bus(1'b1, SN, 32'h0);
    endtask

    task automatic s_trig;
        bus(1'b1, CT, 32'h10);
        ext_trig <= 1'b1;
        repeat (2) @(posedge clk);
        ext_trig <= 1'b0;
        wait_busy(1'b1);
        repeat (20) @(posedge clk);
        ext_trig <= 1'b1;
        repeat (2) @(posedge clk);
        ext_trig <= 1'b0;
        rdc("trig overrun", ST, 32'h20, 32'h20);
        bus(1'b1, 8'h01, 32'h0);
        rdc("trig clear", ST, 32'h20, 32'h0);
        chk("trig abort", 32'(busy), 32'h0);
        bus(1'b1, CT, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_trig = 1'b0;
        conv_sample = 12'h5A5;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_single();
        s_abort();
        s_scan();
        s_cmp();
        s_trig();
        end_sim();
    end
endmodule
